// file: adc_regs_map.svh
// Register offsets, field positions, reset values and serial word counts of the mode registers.
`ifndef ADC_REGS_MAP_SVH
`define ADC_REGS_MAP_SVH

`define ADDR_SW_RESET    7'h00
`define ADDR_OUT_MODE    7'h02
`define ADDR_PAT_HIGH    7'h03
`define ADDR_PAT_LOW     7'h04

`define OM_CUR_MSB       7
`define OM_CUR_LSB       5
`define OM_TERM_BIT      4
`define OM_OFF_BIT       3
`define OM_FMT_MSB       2
`define PH_FORCE_BIT     7
`define PH_UNUSED_BIT    6
`define PH_PAT_MSB       5
`define SW_RESET_BIT     7

`define REG_RESET_VAL    8'h00
`define PAT_HIGH_MASK    8'hBF

`define WORD_BITS        5'h10
`define ADDR_DONE_BITS   5'h08
`define RW_BIT           15

`define CUR_UA_000       14'hDAC
`define CUR_UA_001       14'hFA0
`define CUR_UA_010       14'h1194
`define CUR_UA_100       14'hBB8
`define CUR_UA_101       14'h9C4
`define CUR_UA_110       14'h834
`define CUR_UA_111       14'h6D6

`define WLEN_16          5'h10
`define WLEN_14          5'h0E
`define WLEN_12          5'h0C

`endif

// file: adc_regs_pkg.sv
// Types shared by the mode register bank.
package adc_regs_pkg;

  localparam int NUM_CH   = 4;
  localparam int SAMPLE_W = 14;

  typedef logic [NUM_CH-1:0][SAMPLE_W-1:0] chan_data_t;

  typedef struct packed {
    logic       two_lane;
    logic [4:0] word_bits;
  } fmt_t;

  typedef struct packed {
    logic        sck_d;
    logic [4:0]  cnt;
    logic [15:0] rx;
    logic [7:0]  rd_sh;
    logic        rd_act;
    logic        sdo_oe;
    logic        sdo_lvl;
    logic [7:0]  omode;
    logic [7:0]  tp_hi;
    logic [7:0]  tp_lo;
    logic [13:0] drive_ua;
    logic        term;
    logic        out_en;
    fmt_t        fmt;
    logic        pat_on;
    chan_data_t  chan;
  } state_t;

endpackage

// file: pin_sync.sv
// Two-stage synchroniser for a group of pins from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int           W       = 3,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock, reset, enable.
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  input  wire logic         i_ce,
  // Pins in, synchronised levels out.
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } sync_state_t;

  sync_state_t s_r;
  sync_state_t s_nxt;

  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.meta = i_async;
    s_nxt.sync = s_r.meta;
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      s_r <= '{meta: RST_VAL, sync: RST_VAL};
    end
    else if (i_ce)
    begin
      s_r <= s_nxt;
    end
  end

  assign o_sync = s_r.sync;

endmodule // pin_sync

`default_nettype wire

// file: adc_mode_regs.sv
// Serial-programmed output mode and test pattern registers of a four-channel converter.
`timescale 1ns/1ps
`default_nettype none
`include "adc_regs_map.svh"

module adc_mode_regs (
  // Clock, reset, enable.
  input  wire logic                    i_clk,
  input  wire logic                    i_resetn,
  input  wire logic                    i_ce,
  // Serial programming port.
  input  wire logic                    i_cs_n,
  input  wire logic                    i_sck,
  input  wire logic                    i_sdi,
  input  wire logic                    i_sdo_in,
  output logic                         o_sdo_out,
  output logic                         o_sdo_oe,
  // Sample path.
  input  wire adc_regs_pkg::chan_data_t i_samples,
  output adc_regs_pkg::chan_data_t     o_chan_data,
  output logic                         o_pattern_active,
  // Output driver and serializer settings.
  output logic [13:0]                  o_drive_current_ua,
  output logic                         o_term_enable,
  output logic                         o_outputs_enable,
  output logic                         o_two_lane,
  output logic [4:0]                   o_word_bits
);

  adc_regs_pkg::state_t s_r;
  adc_regs_pkg::state_t s_nxt;
  logic [2:0]           pins_s;
  logic                 cs_n_s;
  logic                 sck_s;
  logic                 sdi_s;
  logic                 sck_rise;
  logic                 sck_fall;
  logic [15:0]          word;

  // Chip select idles high so a reset never looks like a frame start.
  pin_sync #(
    .W       (3),
    .RST_VAL (3'h1)
  ) u_pin_sync (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_ce     (i_ce),
    .i_async  ({i_sdi, i_sck, i_cs_n}),
    .o_sync   (pins_s)
  );

  assign cs_n_s   = pins_s[0];
  assign sck_s    = pins_s[1];
  assign sdi_s    = pins_s[2];
  assign sck_rise = sck_s & ~s_r.sck_d;
  assign sck_fall = ~sck_s & s_r.sck_d;
  assign word     = {s_r.rx[14:0], sdi_s};

  // Code 011 falls back to the reset current so the pads stay in a known state.
  function automatic logic [13:0] cur_ua(input logic [2:0] sel);
    logic [13:0] ua;
    ua = `CUR_UA_000;
    case (sel)
      3'h1:    ua = `CUR_UA_001;
      3'h2:    ua = `CUR_UA_010;
      3'h4:    ua = `CUR_UA_100;
      3'h5:    ua = `CUR_UA_101;
      3'h6:    ua = `CUR_UA_110;
      3'h7:    ua = `CUR_UA_111;
      default: ua = `CUR_UA_000;
    endcase
    return ua;
  endfunction

  // Codes 011 and 100 fall back to two lanes of 16 bits, the reset format.
  function automatic adc_regs_pkg::fmt_t fmt_decode(input logic [2:0] sel);
    adc_regs_pkg::fmt_t f;
    f = '{two_lane: 1'b1, word_bits: `WLEN_16};
    case (sel)
      3'h1:    f = '{two_lane: 1'b1, word_bits: `WLEN_14};
      3'h2:    f = '{two_lane: 1'b1, word_bits: `WLEN_12};
      3'h5:    f = '{two_lane: 1'b0, word_bits: `WLEN_14};
      3'h6:    f = '{two_lane: 1'b0, word_bits: `WLEN_12};
      3'h7:    f = '{two_lane: 1'b0, word_bits: `WLEN_16};
      default: f = '{two_lane: 1'b1, word_bits: `WLEN_16};
    endcase
    return f;
  endfunction

  // The reset register always reads zero because nothing is stored for it and reg_read has no entry for its address.
  function automatic logic [7:0] reg_read(input logic [6:0] addr,
                                          input adc_regs_pkg::state_t st);
    logic [7:0] d;
    d = 8'h00;
    if (addr == `ADDR_OUT_MODE)
      d = st.omode;
    else if (addr == `ADDR_PAT_HIGH)
      d = st.tp_hi;
    else if (addr == `ADDR_PAT_LOW)
      d = st.tp_lo;
    else
      d = 8'h00;
    return d;
  endfunction

  always_comb
  begin
    s_nxt         = s_r;
    s_nxt.sck_d   = sck_s;
    s_nxt.sdo_lvl = 1'b0;
    if (cs_n_s)
    begin
      s_nxt.cnt    = 5'h00;
      s_nxt.rd_act = 1'b0;
      s_nxt.sdo_oe = 1'b0;
    end
    else if (sck_rise && s_r.cnt < `WORD_BITS)
    begin
      s_nxt.rx  = word;
      s_nxt.cnt = 5'(s_r.cnt + 5'h01);
      if (s_r.cnt == `ADDR_DONE_BITS - 5'h01 && word[7])
      begin
        s_nxt.rd_act = 1'b1;
        s_nxt.rd_sh  = reg_read(word[6:0], s_r);
      end
      if (s_r.cnt == `WORD_BITS - 5'h01 && !word[`RW_BIT])
      begin
        if (word[14:8] == `ADDR_SW_RESET)
        begin
          if (word[`SW_RESET_BIT])
          begin
            s_nxt.omode = `REG_RESET_VAL;
            s_nxt.tp_hi = `REG_RESET_VAL;
            s_nxt.tp_lo = `REG_RESET_VAL;
          end
        end
        else if (word[14:8] == `ADDR_OUT_MODE)
          s_nxt.omode = word[7:0];
        else if (word[14:8] == `ADDR_PAT_HIGH)
          s_nxt.tp_hi = word[7:0] & `PAT_HIGH_MASK;
        else if (word[14:8] == `ADDR_PAT_LOW)
          s_nxt.tp_lo = word[7:0];
      end
    end
    else if (sck_fall && s_r.rd_act)
    begin
      // Open drain: pull low for a zero, release for a one or after the word.
      if (s_r.cnt == `WORD_BITS)
      begin
        s_nxt.rd_act = 1'b0;
        s_nxt.sdo_oe = 1'b0;
      end
      else
      begin
        s_nxt.sdo_oe = ~s_r.rd_sh[7];
        s_nxt.rd_sh  = {s_r.rd_sh[6:0], 1'b0};
      end
    end

    s_nxt.term     = s_nxt.omode[`OM_TERM_BIT];
    s_nxt.drive_ua = 14'(cur_ua(s_nxt.omode[`OM_CUR_MSB:`OM_CUR_LSB]) << s_nxt.term);
    s_nxt.out_en   = ~s_nxt.omode[`OM_OFF_BIT];
    s_nxt.fmt      = fmt_decode(s_nxt.omode[`OM_FMT_MSB:0]);
    s_nxt.pat_on   = s_nxt.tp_hi[`PH_FORCE_BIT];
    for (int i = 0; i < adc_regs_pkg::NUM_CH; i++)
    begin
      s_nxt.chan[i] = s_nxt.pat_on ? {s_nxt.tp_hi[`PH_PAT_MSB:0], s_nxt.tp_lo}
                                   : i_samples[i];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      s_r         <= '0;
      s_r.out_en  <= 1'b1;
      s_r.drive_ua <= `CUR_UA_000;
      s_r.fmt     <= '{two_lane: 1'b1, word_bits: `WLEN_16};
    end
    else if (i_ce)
    begin
      s_r <= s_nxt;
    end
  end

  assign o_sdo_out          = s_r.sdo_lvl;
  assign o_sdo_oe           = s_r.sdo_oe;
  assign o_chan_data        = s_r.chan;
  assign o_pattern_active   = s_r.pat_on;
  assign o_drive_current_ua = s_r.drive_ua;
  assign o_term_enable      = s_r.term;
  assign o_outputs_enable   = s_r.out_en;
  assign o_two_lane         = s_r.fmt.two_lane;
  assign o_word_bits        = s_r.fmt.word_bits;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  logic last_edge;
  assign last_edge = i_ce && !cs_n_s && sck_rise && s_r.cnt == `WORD_BITS - 5'h01;

  AST_CUR_1750: assert property ((s_r.omode[7:5] == 3'h7 && !s_r.omode[4])
    |-> o_drive_current_ua == `CUR_UA_111) else $error("1.75 mA code gives wrong current");
  AST_TERM_DOUBLE: assert property (s_r.omode[7:5] == 3'h5 && s_r.omode[4]
    |-> o_term_enable && o_drive_current_ua == 14'h1388) else $error("termination not doubling");
  AST_OUT_OFF: assert property (s_r.omode[3] == !o_outputs_enable)
    else $error("output disable not followed");
  AST_FMT_TWO14: assert property (s_r.omode[2:0] == 3'h1
    |-> o_two_lane && o_word_bits == `WLEN_14) else $error("two-lane 14-bit format wrong");
  AST_FMT_ONE16: assert property (s_r.omode[2:0] == 3'h7
    |-> !o_two_lane && o_word_bits == `WLEN_16) else $error("one-lane 16-bit format wrong");
  AST_UNUSED: assert property (s_r.omode[7:5] == 3'h3 && s_r.omode[2:0] == 3'h4
    && !s_r.omode[4]
    |-> o_two_lane && o_word_bits == `WLEN_16 && o_drive_current_ua == `CUR_UA_000)
    else $error("unused codes not at defaults");
  AST_PATTERN: assert property (s_r.tp_hi[7]
    |-> o_chan_data[3] == {s_r.tp_hi[5:0], s_r.tp_lo} && o_chan_data[0] == o_chan_data[3])
    else $error("pattern not forced on channels");
  AST_FRAME_END: assert property (i_ce && cs_n_s |=> s_r.cnt == 5'h00 && !o_sdo_oe)
    else $error("frame end not cleared");
  AST_READ_KEEP: assert property (last_edge && word[`RW_BIT]
    |=> $stable({s_r.omode, s_r.tp_hi, s_r.tp_lo})) else $error("read changed a register");
  AST_SW_RESET: assert property (last_edge && !word[`RW_BIT]
    && word[14:8] == `ADDR_SW_RESET && word[`SW_RESET_BIT]
    |=> s_r.omode == 8'h00 && s_r.tp_hi == 8'h00 && s_r.tp_lo == 8'h00
    && o_drive_current_ua == `CUR_UA_000)
    else $error("software reset left bits set");

  COV_READ: cover property (last_edge && word[`RW_BIT]);
  COV_WRITE: cover property (last_edge && !word[`RW_BIT] && word[14:8] == `ADDR_OUT_MODE);
  COV_RESET: cover property (last_edge && !word[`RW_BIT] && word[14:8] == `ADDR_SW_RESET);
  COV_PATTERN: cover property ($rose(o_pattern_active));

endmodule // adc_mode_regs

`default_nettype wire

// file: spi_host.sv
// Host model that drives the serial programming port of the mode registers.
`timescale 1ns/1ps
`default_nettype none

module spi_host (
  // Serial port pins.
  output var logic o_cs_n,
  output var logic o_sck,
  output var logic o_sdi,
  input  wire logic i_sdo
);
  localparam int HALF_NS = 400;

  initial
  begin
    o_cs_n = 1'b1;
    o_sck  = 1'b0;
    o_sdi  = 1'b0;
  end

  // Sends the first n bits of a word, MSB first; rd keeps the last eight bits seen on the wire.
  task automatic xfer(input logic [15:0] w, input int n, output logic [7:0] rd);
    rd = 8'h00;
    #37;
    o_cs_n = 1'b0;
    #(HALF_NS);
    for (int i = 15; i > 15 - n; i--)
    begin
      o_sdi = w[i];
      #(HALF_NS);
      o_sck = 1'b1;
      rd = {rd[6:0], i_sdo};
      #(HALF_NS);
      o_sck = 1'b0;
    end
    o_cs_n = 1'b1;
    // A released line must not keep its last level, or a stale bit could pass for data.
    o_sdi = ~o_sdi;
    #(2 * HALF_NS);
  endtask
endmodule // spi_host

`default_nettype wire

// file: adc_output_mode_test_pattern_regs_test.sv
// Self-checking bench for the output mode and test pattern registers.
`timescale 1ns/1ps
`default_nettype none
`include "adc_regs_map.svh"

module adc_output_mode_test_pattern_regs_test;
  typedef struct packed {
    logic [7:0]  om;
    logic [21:0] exp;
  } row_t;

  localparam adc_regs_pkg::chan_data_t SMP = {14'h1111, 14'h2A2A, 14'h3333, 14'h0ABC};
  localparam logic [21:0] RST_SET = {14'hDAC, 3'b011, `WLEN_16};

  logic                     clk, resetn, ce, cs_n, sck, sdi, sdo_oe, sdo_out, sdo_wire;
  logic                     pat_on, term, oen, two;
  logic [13:0]              ua;
  logic [4:0]               wb;
  logic [7:0]               rd;
  logic [21:0]              sets;
  adc_regs_pkg::chan_data_t smp, chan;
  int                       errors, total_checks;

  // Settings as {current, termination, enable, two lanes, word bits}.
  row_t rows [9] = '{
    '{8'h00, RST_SET},
    '{8'h21, {14'hFA0, 3'b011, `WLEN_14}},
    '{8'h42, {14'h1194, 3'b011, `WLEN_12}},
    '{8'h8D, {14'hBB8, 3'b000, `WLEN_14}},
    '{8'hB6, {14'h1388, 3'b110, `WLEN_12}},
    '{8'hD7, {14'h1068, 3'b110, `WLEN_16}},
    '{8'hF8, {14'hDAC, 3'b101, `WLEN_16}},
    '{8'hE3, {14'h6D6, 3'b011, `WLEN_16}},
    '{8'h64, {14'hDAC, 3'b011, `WLEN_16}}
  };

  // The wire is pulled up; the device can only pull it low.
  assign sdo_wire = sdo_oe ? sdo_out : 1'b1;
  assign sets = {ua, term, oen, two, wb};

  adc_mode_regs i_dut (
    .i_clk              (clk),
    .i_resetn           (resetn),
    .i_ce               (ce),
    .i_cs_n             (cs_n),
    .i_sck              (sck),
    .i_sdi              (sdi),
    .i_sdo_in           (sdo_wire),
    .o_sdo_out          (sdo_out),
    .o_sdo_oe           (sdo_oe),
    .i_samples          (smp),
    .o_chan_data        (chan),
    .o_pattern_active   (pat_on),
    .o_drive_current_ua (ua),
    .o_term_enable      (term),
    .o_outputs_enable   (oen),
    .o_two_lane         (two),
    .o_word_bits        (wb)
  );

  spi_host i_host (
    .o_cs_n (cs_n),
    .o_sck  (sck),
    .o_sdi  (sdi),
    .i_sdo  (sdo_wire)
  );

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic final_report;
    $display("Checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk_val(input string nm, input logic [21:0] exp, input logic [21:0] got);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Applies samples and looks at the channel outputs one clock later.
  task automatic chk_chan(input adc_regs_pkg::chan_data_t v, input adc_regs_pkg::chan_data_t exp);
    @(posedge clk);
    smp <= v;
    @(posedge clk);
    @(negedge clk);
    total_checks++;
    if (chan !== exp)
    begin
      errors++;
      $display("MISMATCH chan_data expected %h seen %h", exp, chan);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_host.xfer({1'b0, a, d}, 16, rd);
  endtask

  // Data bits of a read are junk on purpose; the device must ignore them.
  task automatic rdchk(input string nm, input logic [6:0] a, input logic [7:0] exp);
    i_host.xfer({1'b1, a, 8'h5A}, 16, rd);
    chk_val(nm, {14'h0, exp}, {14'h0, rd});
  endtask

  initial
  begin
    repeat (100000) @(posedge clk);
    errors++;
    final_report;
  end

  initial
  begin
    resetn = 1'b0;
    ce = 1'b1;
    smp = '0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk_val("reset settings", RST_SET, sets);
    rdchk("reset out mode", `ADDR_OUT_MODE, 8'h00);
    foreach (rows[i])
    begin
      wr(`ADDR_OUT_MODE, rows[i].om);
      chk_val("settings", rows[i].exp, sets);
      rdchk("out mode readback", `ADDR_OUT_MODE, rows[i].om);
    end
    rdchk("out mode kept", `ADDR_OUT_MODE, 8'h64);
    wr(`ADDR_PAT_LOW, 8'hA5);
    wr(`ADDR_PAT_HIGH, 8'hE5);
    rdchk("pattern high", `ADDR_PAT_HIGH, 8'hA5);
    rdchk("pattern low", `ADDR_PAT_LOW, 8'hA5);
    chk_val("pattern flag", 22'h1, {21'h0, pat_on});
    chk_chan(SMP, {4{14'h25A5}});
    wr(`ADDR_PAT_HIGH, 8'h2A);
    chk_val("pattern flag off", 22'h0, {21'h0, pat_on});
    chk_chan(SMP, SMP);
    // A word cut short one bit before the end must write nothing.
    i_host.xfer({1'b0, `ADDR_PAT_LOW, 8'h3C}, 15, rd);
    rdchk("aborted write", `ADDR_PAT_LOW, 8'hA5);
    wr(7'h01, 8'hFF);
    rdchk("unmapped", 7'h01, 8'h00);
    // A reset word without its command bit must leave the registers alone.
    wr(`ADDR_OUT_MODE, 8'hB6);
    wr(`ADDR_SW_RESET, 8'h7F);
    rdchk("reset bit clear", `ADDR_OUT_MODE, 8'hB6);
    wr(`ADDR_SW_RESET, 8'h80);
    rdchk("sw reset out mode", `ADDR_OUT_MODE, 8'h00);
    rdchk("sw reset high", `ADDR_PAT_HIGH, 8'h00);
    rdchk("sw reset low", `ADDR_PAT_LOW, 8'h00);
    rdchk("reset bit", `ADDR_SW_RESET, 8'h00);
    chk_val("sw reset settings", RST_SET, sets);
    // With the enable low even the pin synchronisers stop, so a whole word is lost.
    @(posedge clk);
    ce <= 1'b0;
    wr(`ADDR_OUT_MODE, 8'hB6);
    @(posedge clk);
    ce <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk_val("frozen write settings", RST_SET, sets);
    rdchk("frozen write", `ADDR_OUT_MODE, 8'h00);
    // A second hardware reset in mid-run must bring back the same defaults.
    wr(`ADDR_OUT_MODE, 8'hB6);
    wr(`ADDR_PAT_HIGH, 8'hFF);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk_val("mid-run reset settings", RST_SET, sets);
    chk_val("mid-run reset pattern", 22'h0, {21'h0, pat_on});
    rdchk("mid-run reset high", `ADDR_PAT_HIGH, 8'h00);
    final_report;
  end
endmodule // adc_output_mode_test_pattern_regs_test

`default_nettype wire
